// ### logic/spc_pkg.sv
// shared constants and carrier types for the stop-point controller
package spc_pkg;
  // clock rate and power-up pause
  localparam int CLK_MHZ = 100;
  localparam int PAUSE_US = 200;
  localparam int PAUSE_CYC = PAUSE_US * CLK_MHZ;
  // number of wake-up row cycles and serial clocks at init
  localparam int INIT_ROW_CYCLES = 8;
  localparam int INIT_SHIFT_CLOCKS = 2;
  // strobe phase lengths in clock cycles (row low, row high, column delay)
  localparam logic [3:0] ROW_LOW_CYC = 4'h8;
  localparam logic [3:0] ROW_HIGH_CYC = 4'h6;
  localparam logic [3:0] COL_DELAY_CYC = 4'h3;
  // partition-length codes on row bits 7..4
  localparam logic [3:0] PART_16 = 4'h0;
  localparam logic [3:0] PART_32 = 4'h1;
  localparam logic [3:0] PART_64 = 4'h3;
  localparam logic [3:0] PART_128 = 4'h7;
  localparam int PART_LSB = 4;
  // column bit positions that swap in stop-point mode
  localparam int COL_BIT_SEVEN = 7;
  localparam int COL_BIT_EIGHT = 8;

  // user command codes
  typedef enum logic [2:0] {
    SPC_CMD_READ = 3'h0,
    SPC_CMD_WRITE = 3'h1,
    SPC_CMD_REFRESH = 3'h2,
    SPC_CMD_FULL_XFER = 3'h3,
    SPC_CMD_SPLIT_XFER = 3'h4,
    SPC_CMD_STOP_SET = 3'h5,
    SPC_CMD_OPT_RESET = 3'h6
  } spc_cmd_e;

  // one user request
  typedef struct packed {
    spc_cmd_e cmd;
    logic [8:0] row;
    logic [8:0] col;
    logic half_sel;
    logic [3:0] part_code;
  } spc_req_s;

  // strobe and address pins toward the memory
  typedef struct packed {
    logic row_strobe_n;
    logic column_strobe_low_byte_n;
    logic column_strobe_high_byte_n;
    logic write_strobe_n;
    logic transfer_output_gate_n;
    logic special_function_select;
    logic serial_shift_clock;
    logic [8:0] addr;
  } spc_pins_s;

  // partition length in words for a code; unknown codes fall to 128
  function automatic logic [7:0] spc_part_len(input logic [3:0] code);
    case (code)
      PART_16: spc_part_len = 8'h10;
      PART_32: spc_part_len = 8'h20;
      PART_64: spc_part_len = 8'h40;
      default: spc_part_len = 8'h80;
    endcase
  endfunction
endpackage

// ### logic/spc_col_map.sv
// column address mapping for normal and stop-point mode
`timescale 1ns/1ps
module spc_col_map
  import spc_pkg::*;
(
  // mode and requested column
  input wire logic stop_mode,
  input wire logic split_xfer,
  input wire logic half_sel,
  input wire logic [8:0] col_in,
  // column as driven on the pins
  output logic [8:0] col_out
);
  // place the half select where the device will look for it
  always_comb begin
    col_out = col_in;
    if (split_xfer) begin
      if (stop_mode) begin
        col_out[COL_BIT_SEVEN] = half_sel;
        col_out[COL_BIT_EIGHT] = 1'b0;
      end else begin
        col_out[COL_BIT_EIGHT] = half_sel;
        col_out[COL_BIT_SEVEN] = 1'b0;
      end
    end else if (stop_mode) begin
      // device swaps the bits internally, so pre-swap to keep linear columns
      col_out[COL_BIT_SEVEN] = col_in[COL_BIT_EIGHT];
      col_out[COL_BIT_EIGHT] = col_in[COL_BIT_SEVEN];
    end
  end
endmodule

// ### logic/spc_ctrl.sv
// controller driving the video memory strobes, init and stop-point set
`timescale 1ns/1ps
module spc_ctrl
  import spc_pkg::*;
#(
  parameter int PAUSE_CYCLES = PAUSE_CYC
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // user request port
  input wire logic req_valid,
  input spc_req_s req,
  output logic req_ready,
  output logic init_done,
  output logic stop_mode,
  output logic [7:0] part_len,
  output logic half_flag,
  // memory pins
  output spc_pins_s pins,
  input wire logic half_indicator_flag
);
  // controller phases, one-hot
  typedef enum logic [6:0] {
    ST_PAUSE = 7'h01,
    ST_WAKE = 7'h02,
    ST_XFER = 7'h04,
    ST_SHIFT = 7'h08,
    ST_SET = 7'h10,
    ST_IDLE = 7'h20,
    ST_CYCLE = 7'h40
  } spc_state_e;

  // whole module state
  typedef struct packed {
    spc_state_e st;
    logic [31:0] cnt;
    logic [3:0] ph;
    logic [3:0] n;
    spc_req_s cur;
    logic stop;
    logic [7:0] plen;
    logic done;
    logic ready;
    logic [1:0] qsync;
    logic half;
    spc_pins_s p;
  } spc_ctl_s;

  spc_ctl_s s_q; // registered state
  spc_ctl_s s_d; // next state
  logic [8:0] col_mapped; // column after mode mapping
  logic split_now; // current cycle is a split transfer

  assign split_now = (s_q.cur.cmd == SPC_CMD_SPLIT_XFER);

  // column bit placement for the active mode
  spc_col_map u_col_map (
    .stop_mode(s_q.stop),
    .split_xfer(split_now),
    .half_sel(s_q.cur.half_sel),
    .col_in(s_q.cur.col),
    .col_out(col_mapped)
  );

  // build a request for the internal init sequence
  function automatic spc_req_s mk_req(input spc_cmd_e c, input logic [3:0] code);
    spc_req_s r;
    r = '0;
    r.cmd = c;
    r.part_code = code;
    mk_req = r;
  endfunction

  // next-state logic: one strobe cycle engine shared by all commands
  always_comb begin
    s_d = s_q;
    s_d.ready = 1'b0;
    // half flag pin comes from outside: three flops before use
    s_d.qsync = {s_q.qsync[0], half_indicator_flag};
    s_d.half = s_q.qsync[1];
    case (s_q.st)
      ST_PAUSE: begin
        s_d.cnt = s_q.cnt + 32'h1;
        if (s_q.cnt == 32'(PAUSE_CYCLES - 1)) begin
          s_d.st = ST_WAKE;
          s_d.cnt = '0;
          s_d.n = '0;
          s_d.cur = mk_req(SPC_CMD_REFRESH, PART_128);
        end
      end
      ST_WAKE, ST_XFER, ST_SET, ST_CYCLE: begin
        // row low phase then row high phase
        s_d.ph = s_q.ph + 4'h1;
        if (s_q.ph == 4'h0) begin
          // row address set up one cycle before the row strobe falls
          s_d.p.addr = s_q.cur.row;
          if (s_q.cur.cmd == SPC_CMD_STOP_SET) begin
            // set cycle: column strobes and write low, select high at row fall
            s_d.p.addr = '0;
            s_d.p.addr[PART_LSB +: 4] = s_q.cur.part_code;
          end
        end else if (s_q.ph == 4'h1) begin
          // row fall a cycle after the qualifiers, so column-first cycles are real
          s_d.p.row_strobe_n = 1'b0;
        end else if (s_q.ph == COL_DELAY_CYC) begin
          s_d.p.addr = col_mapped;
          if (s_q.cur.cmd == SPC_CMD_READ || s_q.cur.cmd == SPC_CMD_WRITE) begin
            s_d.p.column_strobe_low_byte_n = 1'b0;
            s_d.p.column_strobe_high_byte_n = 1'b0;
          end
          if (s_q.cur.cmd == SPC_CMD_FULL_XFER || split_now) begin
            s_d.p.column_strobe_low_byte_n = 1'b0;
            s_d.p.transfer_output_gate_n = 1'b1;
          end
        end else if (s_q.ph == ROW_LOW_CYC) begin
          // release all strobes
          s_d.p.row_strobe_n = 1'b1;
          s_d.p.column_strobe_low_byte_n = 1'b1;
          s_d.p.column_strobe_high_byte_n = 1'b1;
          s_d.p.write_strobe_n = 1'b1;
          s_d.p.transfer_output_gate_n = 1'b1;
          s_d.p.special_function_select = 1'b0;
        end else if (s_q.ph == ROW_LOW_CYC + ROW_HIGH_CYC) begin
          s_d.ph = '0;
          s_d.p.addr = '0;
          case (s_q.cur.cmd)
            SPC_CMD_STOP_SET: begin
              s_d.stop = 1'b1;
              s_d.plen = spc_part_len(s_q.cur.part_code);
            end
            SPC_CMD_REFRESH, SPC_CMD_OPT_RESET: begin
              // both put the same column-first levels on the pins, so either ends the mode
              s_d.stop = 1'b0;
              s_d.plen = spc_part_len(PART_128);
            end
            default: begin
            end
          endcase
          case (s_q.st)
            ST_WAKE: begin
              s_d.n = s_q.n + 4'h1;
              if (s_q.n == 4'(INIT_ROW_CYCLES - 1)) begin
                s_d.st = ST_XFER;
                s_d.cur = mk_req(SPC_CMD_FULL_XFER, PART_128);
              end
            end
            ST_XFER: begin
              s_d.st = ST_SHIFT;
              s_d.n = '0;
            end
            ST_SET: begin
              s_d.st = ST_IDLE;
              s_d.done = 1'b1;
              s_d.ready = 1'b1;
            end
            default: begin
              s_d.st = ST_IDLE;
              s_d.ready = 1'b1;
            end
          endcase
        end
        // pre-fall setup one cycle ahead so levels are stable at row fall
        if (s_q.ph == 4'h0) begin
          case (s_q.cur.cmd)
            SPC_CMD_REFRESH, SPC_CMD_OPT_RESET: begin
              // column-before-row refresh: column strobes already low
              s_d.p.column_strobe_low_byte_n = 1'b0;
              s_d.p.column_strobe_high_byte_n = 1'b0;
            end
            SPC_CMD_STOP_SET: begin
              s_d.p.column_strobe_low_byte_n = 1'b0;
              s_d.p.column_strobe_high_byte_n = 1'b0;
              s_d.p.write_strobe_n = 1'b0;
              s_d.p.special_function_select = 1'b1;
            end
            SPC_CMD_FULL_XFER: begin
              s_d.p.transfer_output_gate_n = 1'b0;
              s_d.p.special_function_select = 1'b0;
            end
            SPC_CMD_SPLIT_XFER: begin
              s_d.p.transfer_output_gate_n = 1'b0;
              s_d.p.special_function_select = 1'b1;
            end
            SPC_CMD_WRITE: s_d.p.write_strobe_n = 1'b0;
            default: begin
            end
          endcase
        end
      end
      ST_SHIFT: begin
        // two whole serial clocks, each a high then a low cycle
        s_d.p.serial_shift_clock = ~s_q.p.serial_shift_clock;
        if (s_q.p.serial_shift_clock) begin
          s_d.n = s_q.n + 4'h1;
          if (s_q.n == 4'(INIT_SHIFT_CLOCKS - 1)) begin
            s_d.st = ST_SET;
            s_d.cur = mk_req(SPC_CMD_STOP_SET, PART_128);
          end
        end
      end
      ST_IDLE: begin
        s_d.ready = 1'b1;
        if (req_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.cur = req;
          s_d.st = ST_CYCLE;
          s_d.ph = '0;
        end
      end
      default: s_d.st = ST_PAUSE;
    endcase
  end

  // state register; strobe pins idle high except select and shift clock
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= ST_PAUSE;
      s_q.plen <= 8'h80;
      s_q.p.row_strobe_n <= 1'b1;
      s_q.p.column_strobe_low_byte_n <= 1'b1;
      s_q.p.column_strobe_high_byte_n <= 1'b1;
      s_q.p.write_strobe_n <= 1'b1;
      s_q.p.transfer_output_gate_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign req_ready = s_q.ready;
  assign init_done = s_q.done;
  assign stop_mode = s_q.stop;
  assign part_len = s_q.plen;
  assign half_flag = s_q.half;
  assign pins = s_q.p;
endmodule

// ### test/spc_ctrl_asserts.sv
// port checker for the stop-point controller
`timescale 1ns/1ps
module spc_ctrl_chk
  import spc_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // user side
  input wire logic req_valid,
  input spc_req_s req,
  input wire logic req_ready,
  input wire logic init_done,
  input wire logic stop_mode,
  input wire logic [7:0] part_len,
  input wire logic half_flag,
  // memory side
  input spc_pins_s pins,
  input wire logic half_indicator_flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // a request of one kind being taken
  sequence take_s(spc_cmd_e c);
    req_valid && req_ready && req.cmd == c;
  endsequence
  // row strobe just went low
  sequence fall_s;
    $fell(pins.row_strobe_n);
  endsequence
  reset_idle_a: assert property ($fell(rst) |-> !stop_mode && part_len == 8'h80)
    else $error("reset state wrong");
  busy_hold_a: assert property (req_valid && req_ready |=> !req_ready [*8])
    else $error("ready came back too early");
  ready_back_a: assert property (req_valid && req_ready |-> ##[15:17] req_ready)
    else $error("ready did not come back");
  mode_on_a: assert property (take_s(SPC_CMD_STOP_SET) |-> ##[15:17] stop_mode)
    else $error("set cycle left mode off");
  mode_off_a: assert property (take_s(SPC_CMD_OPT_RESET) |-> ##[15:17] !stop_mode)
    else $error("option reset kept mode on");
  len_32_a: assert property (take_s(SPC_CMD_STOP_SET) ##0 req.part_code == PART_32
    |-> ##[15:17] part_len == 8'h20) else $error("length 32 not set");
  len_legal_a: assert property (stop_mode |-> part_len inside {8'h10, 8'h20, 8'h40, 8'h80})
    else $error("illegal length");
  set_pins_a: assert property (fall_s ##0 (pins.special_function_select && !pins.write_strobe_n)
    |-> !(pins.column_strobe_low_byte_n && pins.column_strobe_high_byte_n))
    else $error("set cycle without column strobe");
  split_pins_a: assert property (fall_s ##0 (pins.special_function_select && pins.write_strobe_n)
    |-> !pins.transfer_output_gate_n) else $error("split transfer without gate");
  init_set_a: assert property ($rose(init_done) |-> stop_mode)
    else $error("init ended without set cycle");
endmodule
bind spc_ctrl spc_ctrl_chk i_spc_ctrl_chk (.mclk(mclk), .rst(rst), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .init_done(init_done), .stop_mode(stop_mode),
  .part_len(part_len), .half_flag(half_flag), .pins(pins),
  .half_indicator_flag(half_indicator_flag));

// ### test/spc_mem_model.sv
// behavioural video memory watching the controller strobes
`timescale 1ns/1ps
module spc_mem_model
  import spc_pkg::*;
(
  // strobes from the controller
  input spc_pins_s pins,
  // half indicator back to the controller
  output logic half_indicator_flag
);
  logic stop_q = 1'b0; // mode off at power-up
  logic [3:0] code_q = 4'h7; // partition code, two halves by default
  logic [8:0] pcol_q = 9'h000; // last column seen on the pins
  logic xfer_q = 1'b0;
  logic split_q = 1'b0;
  int rows = 0;
  int init_rows = -1; // row cycles before the first full transfer
  int shifts = 0;
  wire cas_n = pins.column_strobe_low_byte_n & pins.column_strobe_high_byte_n;
  initial half_indicator_flag = 1'b0;
  // cycle kind is decided at the row strobe fall
  always @(negedge pins.row_strobe_n) begin
    rows++;
    xfer_q = !pins.transfer_output_gate_n && pins.write_strobe_n;
    split_q = pins.special_function_select;
    if (!cas_n && !pins.write_strobe_n && pins.special_function_select) begin
      stop_q = 1'b1;
      code_q = pins.addr[7:4];
    end else if (!cas_n) begin
      stop_q = 1'b0; // any column-first refresh leaves the mode
    end
  end
  // column latch; bit roles depend on the mode
  always @(negedge cas_n) begin
    if (!pins.row_strobe_n) begin
      pcol_q = pins.addr;
      if (xfer_q && !split_q) begin
        if (init_rows < 0) init_rows = rows - 1;
        half_indicator_flag = pins.addr[7]; // tap half sets the flag
      end
    end
  end
  // shift clocks after the first transfer
  always @(posedge pins.serial_shift_clock) begin
    if (init_rows >= 0) shifts++;
  end
endmodule

// ### test/tb_top.sv
// self-checking bench for the stop-point controller
`timescale 1ns/1ps
module tb_top;
  import spc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  spc_req_s req = '0;
  logic req_ready, init_done, stop_mode, half_flag, hif;
  logic [7:0] part_len;
  spc_pins_s pins;
  int fails = 0;
  int checked = 0;
  always #5 mclk = ~mclk;
  // short pause keeps the run small
  spc_ctrl #(.PAUSE_CYCLES(20)) i_spc_ctrl (.mclk(mclk), .rst(rst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .init_done(init_done), .stop_mode(stop_mode),
    .part_len(part_len), .half_flag(half_flag), .pins(pins), .half_indicator_flag(hif));
  spc_mem_model i_spc_mem_model (.pins(pins), .half_indicator_flag(hif));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // bounded wait on a flag, at falling edges
  task automatic wait_high(ref logic f);
    int n;
    n = 0;
    while (f !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      report_and_stop();
    end
  endtask
  task automatic do_cmd(input spc_cmd_e c, input logic [8:0] col, input logic hs,
                        input logic [3:0] pc);
    wait_high(req_ready);
    req = '{c, 9'h10F, col, hs, pc};
    req_valid = 1'b1;
    @(negedge mclk);
    req_valid = 1'b0;
    @(negedge mclk);
    wait_high(req_ready);
  endtask
  // power-up sequence as seen by the memory
  task automatic chk_init();
    wait_high(init_done);
    check("wake rows", 9'h1, {8'h0, i_spc_mem_model.init_rows >= 8});
    check("shift clocks", 9'h2, i_spc_mem_model.shifts[8:0]);
    check("stop mode", 9'h3, {i_spc_mem_model.stop_q, stop_mode});
    check("part_len", 9'h080, {1'b0, part_len});
    check("half flag", 9'h0, {8'h0, half_flag});
  endtask
  // every length code, plus one unlisted code
  task automatic chk_codes();
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'h5};
    logic [7:0] lens [5] = '{8'h10, 8'h20, 8'h40, 8'h80, 8'h80};
    for (int i = 0; i < 5; i++) begin
      do_cmd(SPC_CMD_STOP_SET, 9'h000, 1'b0, codes[i]);
      check("part_len", {1'b0, lens[i]}, {1'b0, part_len});
      check("code", {5'h0, codes[i]}, {5'h0, i_spc_mem_model.code_q});
    end
  endtask
  // column bits in stop-point mode
  task automatic chk_swap();
    do_cmd(SPC_CMD_READ, 9'h080, 1'b0, 4'h0);
    check("swap col", 9'h100, i_spc_mem_model.pcol_q);
    do_cmd(SPC_CMD_SPLIT_XFER, 9'h005, 1'b1, 4'h0);
    check("split col", 9'h085, i_spc_mem_model.pcol_q);
  endtask
  // leave the mode, then normal mapping and half flag
  task automatic chk_exit();
    do_cmd(SPC_CMD_OPT_RESET, 9'h000, 1'b0, 4'h0);
    check("mode off", 9'h0, {i_spc_mem_model.stop_q, stop_mode});
    do_cmd(SPC_CMD_READ, 9'h080, 1'b0, 4'h0);
    check("plain col", 9'h080, i_spc_mem_model.pcol_q);
    do_cmd(SPC_CMD_SPLIT_XFER, 9'h005, 1'b1, 4'h0);
    check("split col", 9'h105, i_spc_mem_model.pcol_q);
    do_cmd(SPC_CMD_FULL_XFER, 9'h080, 1'b0, 4'h0);
    check("flag high", 9'h1, {8'h0, half_flag});
    do_cmd(SPC_CMD_FULL_XFER, 9'h000, 1'b0, 4'h0);
    check("flag low", 9'h0, {8'h0, half_flag});
  endtask
  // a plain column-first refresh also ends the mode
  task automatic chk_refresh();
    do_cmd(SPC_CMD_STOP_SET, 9'h000, 1'b0, PART_64);
    check("mode on", 9'h3, {i_spc_mem_model.stop_q, stop_mode});
    check("part_len", 9'h040, {1'b0, part_len});
    do_cmd(SPC_CMD_REFRESH, 9'h000, 1'b0, 4'h0);
    check("refresh exit", 9'h0, {i_spc_mem_model.stop_q, stop_mode});
    check("part_len", 9'h080, {1'b0, part_len});
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    chk_init();
    chk_codes();
    chk_swap();
    chk_exit();
    chk_refresh();
    report_and_stop();
  end
endmodule
